// >>> hbc_pkg.sv
// package for the h-bridge control and chopper block
package hbc_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;

  // times in their own units, counts derived (us times exact, ns times round up to whole cycles)
  localparam int SLEEP_US        = 1000;
  localparam int SLEEP_CYC       = SLEEP_US * (CLK_HZ / 1_000_000);
  localparam int WAKE_US         = 250;
  localparam int WAKE_CYC        = WAKE_US * (CLK_HZ / 1_000_000);
  localparam int OFF_US          = 25;
  localparam int OFF_CYC         = OFF_US * (CLK_HZ / 1_000_000);
  localparam int BLANK_US        = 2;
  localparam int BLANK_CYC       = BLANK_US * (CLK_HZ / 1_000_000);
  localparam int OCP_NS          = 1500;
  localparam int OCP_CYC         = (OCP_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEAD_NS         = 200;
  localparam int DEAD_CYC        = (DEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEGLITCH_NS     = 300;
  localparam int DEGLITCH_CYC    = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAX_PWM_KHZ     = 200;
  // half period of the fastest modulation must outlast filter plus dead time
  localparam int MIN_HALF_NS     = 1_000_000 / MAX_PWM_KHZ / 2;

  // drive code of one half-bridge
  typedef enum logic [1:0] {
    HBC_LEG_FLOAT,
    HBC_LEG_HIGH,
    HBC_LEG_LOW
  } hbc_leg_t;

  // gate commands of one half-bridge
  typedef struct packed {
    logic high_on;
    logic low_on;
  } hbc_gate_t;

  typedef enum logic [2:0] {
    HBC_ST_SLEEP,
    HBC_ST_WAKE,
    HBC_ST_ACTIVE,
    HBC_ST_CHOP,
    HBC_ST_FAULT
  } hbc_state_t;

endpackage : hbc_pkg

// >>> hbc_leg.sv
// one half-bridge leg with shoot-through gap
`timescale 1ns/100ps
module hbc_leg
  import hbc_pkg::*;
#(
  parameter int GAP_CYC = DEAD_CYC
)
(
  input  wire logic      clk_sys,
  input  wire logic      rst_n,
  input  hbc_leg_t       leg_req,
  output hbc_gate_t      gate
);

  initial
  begin
    if (GAP_CYC < 1 || GAP_CYC > 255)
      $error("hbc_leg: GAP_CYC out of range");
  end

  logic [7:0] gap_cnt_r;
  hbc_leg_t   cur_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_r     <= HBC_LEG_FLOAT;
      gap_cnt_r <= 8'h00;
    end
    else if (leg_req == cur_r)
      gap_cnt_r <= 8'h00;
    else if (leg_req == HBC_LEG_FLOAT || cur_r == HBC_LEG_FLOAT)
    begin
      cur_r     <= leg_req;
      gap_cnt_r <= 8'h00;
    end
    else if (gap_cnt_r == 8'(GAP_CYC - 1))
    begin
      cur_r     <= leg_req;
      gap_cnt_r <= 8'h00;
    end
    else
      gap_cnt_r <= gap_cnt_r + 8'h01;
  end

  // during the gap both switches are off; a direct switch never happens
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gate <= '0;
    else if (leg_req != cur_r && leg_req != HBC_LEG_FLOAT && cur_r != HBC_LEG_FLOAT)
      gate <= '0;
    else
    begin
      gate.high_on <= (cur_r == HBC_LEG_HIGH);
      gate.low_on  <= (cur_r == HBC_LEG_LOW);
    end
  end

endmodule : hbc_leg

// >>> hbc_core.sv
// h-bridge control: input filter, sleep, chopping and fault handling
`timescale 1ns/100ps
module hbc_core
  import hbc_pkg::*;
#(
  parameter int SLEEP_CNT  = SLEEP_CYC,
  parameter int WAKE_CNT   = WAKE_CYC,
  parameter int OFF_CNT    = OFF_CYC,
  parameter int BLANK_CNT  = BLANK_CYC,
  parameter int OCP_CNT    = OCP_CYC,
  parameter int FILT_CNT   = DEGLITCH_CYC
)
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic bridge_input_a,
  input  wire logic bridge_input_b,
  input  wire logic chop_trip_current,
  input  wire logic overcurrent_fault,
  input  wire logic thermal_fault,
  output hbc_gate_t bridge_output_one,
  output hbc_gate_t bridge_output_two,
  output logic      sleep_active,
  output logic      fault_latched
);

  localparam int TW = 24;

  initial
  begin
    if (SLEEP_CNT < 1 || WAKE_CNT < 1 || OFF_CNT < 1 || BLANK_CNT < 1 || OCP_CNT < 1 || FILT_CNT < 1)
      $error("hbc_core: counts must be at least one");
    if (SLEEP_CNT >= (1 << TW) || WAKE_CNT >= (1 << TW) || OFF_CNT >= (1 << TW))
      $error("hbc_core: count too wide");
    // blank, overcurrent and filter counters are only eight bits wide
    if (BLANK_CNT > 255 || OCP_CNT > 255 || FILT_CNT > 255)
      $error("hbc_core: short count too wide");
    // filter plus gap must fit the fastest modulation half period
    if ((FILT_CNT + DEAD_CYC) * CLK_NS >= MIN_HALF_NS)
      $error("hbc_core: filter too slow for fastest modulation");
  end

  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 5'h00;
      s2_r <= 5'h00;
      s3_r <= 5'h00;
    end
    else
    begin
      s1_r <= {thermal_fault, overcurrent_fault, chop_trip_current, bridge_input_b, bridge_input_a};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a change counts once second and third stage agree
  logic [4:0] sy_r;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sy_r <= 5'h00;
    else
      sy_r <= (s2_r & s3_r) | (sy_r & (s2_r | s3_r));
  end

  logic [1:0] in_f_r;
  logic [7:0] filt_cnt_r [2];

  for (genvar gi = 0; gi < 2; gi++)
  begin : g_filt
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        in_f_r[gi]     <= 1'b0;
        filt_cnt_r[gi] <= 8'h00;
      end
      else if (sy_r[gi] == in_f_r[gi])
        filt_cnt_r[gi] <= 8'h00;
      else if (filt_cnt_r[gi] == 8'(FILT_CNT - 1))
      begin
        in_f_r[gi]     <= sy_r[gi];
        filt_cnt_r[gi] <= 8'h00;
      end
      else
        filt_cnt_r[gi] <= filt_cnt_r[gi] + 8'h01;
    end
  end

  wire logic in_a   = in_f_r[0];
  wire logic in_b   = in_f_r[1];
  wire logic trip   = sy_r[2];
  wire logic oc_raw = sy_r[3];
  wire logic hot    = sy_r[4];
  wire logic idle   = !in_a && !in_b;

  // overcurrent qualifies after OCP_CNT cycles of continuous assertion
  logic [7:0] oc_cnt_r;
  logic       oc_qual;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      oc_cnt_r <= 8'h00;
    else if (!oc_raw)
      oc_cnt_r <= 8'h00;
    else if (oc_cnt_r != 8'(OCP_CNT))
      oc_cnt_r <= oc_cnt_r + 8'h01;
  end

  assign oc_qual = (oc_cnt_r == 8'(OCP_CNT));

  // state machine
  hbc_state_t state_r;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] idle_cnt_r;
  logic [7:0]    blank_cnt_r;

  // count both-low time for sleep entry
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      idle_cnt_r <= '0;
    else if (!idle)
      idle_cnt_r <= '0;
    else if (idle_cnt_r != TW'(SLEEP_CNT))
      idle_cnt_r <= idle_cnt_r + TW'(1);
  end

  wire logic sleep_due = (idle_cnt_r == TW'(SLEEP_CNT));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= HBC_ST_SLEEP;
      tmr_r   <= '0;
    end
    else
    begin
      case (state_r)
        HBC_ST_SLEEP:
        begin
          tmr_r <= '0;
          if (!idle)
            state_r <= HBC_ST_WAKE;
        end
        // input must stay high for the wake interval
        HBC_ST_WAKE:
        begin
          if (idle)
            state_r <= HBC_ST_SLEEP;
          else if (tmr_r == TW'(WAKE_CNT - 1))
          begin
            state_r <= HBC_ST_ACTIVE;
            tmr_r   <= '0;
          end
          else
            tmr_r <= tmr_r + TW'(1);
        end
        HBC_ST_ACTIVE:
        begin
          tmr_r <= '0;
          if (oc_qual)
            state_r <= HBC_ST_FAULT;
          else if (sleep_due)
            state_r <= HBC_ST_SLEEP;
          // live trip starts the off interval, past blanking
          else if (trip && blank_cnt_r == 8'h00 && !idle && !hot)
            state_r <= HBC_ST_CHOP;
        end
        HBC_ST_CHOP:
        begin
          if (oc_qual)
            state_r <= HBC_ST_FAULT;
          else if (tmr_r == TW'(OFF_CNT - 1))
          begin
            state_r <= HBC_ST_ACTIVE;
            tmr_r   <= '0;
          end
          else
            tmr_r <= tmr_r + TW'(1);
        end
        HBC_ST_FAULT:
        begin
          tmr_r <= '0;
          if (sleep_due)
            state_r <= HBC_ST_SLEEP;
        end
        default:
        begin
          state_r <= HBC_ST_SLEEP;
          tmr_r   <= '0;
        end
      endcase
    end
  end

  // blank trip after drive is re-enabled
  logic drive_on;
  logic drive_on_d_r;

  assign drive_on = (state_r == HBC_ST_ACTIVE) && !idle && !hot && !(in_a && in_b);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_on_d_r <= 1'b0;
      blank_cnt_r  <= 8'h00;
    end
    else
    begin
      drive_on_d_r <= drive_on;
      if (drive_on && !drive_on_d_r)
        blank_cnt_r <= 8'(BLANK_CNT);
      else if (blank_cnt_r != 8'h00)
        blank_cnt_r <= blank_cnt_r - 8'h01;
    end
  end

  // bridge decode
  hbc_leg_t req_one;
  hbc_leg_t req_two;

  always_comb
  begin
    req_one = HBC_LEG_FLOAT;
    req_two = HBC_LEG_FLOAT;
    // thermal flag holds all off, auto resume
    if (hot)
    begin
      req_one = HBC_LEG_FLOAT;
      req_two = HBC_LEG_FLOAT;
    end
    // both low switches on during off interval
    else if (state_r == HBC_ST_CHOP)
    begin
      req_one = HBC_LEG_LOW;
      req_two = HBC_LEG_LOW;
    end
    else if (state_r == HBC_ST_ACTIVE)
    begin
      case ({in_a, in_b})
        2'b01:
        begin
          req_one = HBC_LEG_LOW;
          req_two = HBC_LEG_HIGH;
        end
        2'b10:
        begin
          req_one = HBC_LEG_HIGH;
          req_two = HBC_LEG_LOW;
        end
        2'b11:
        begin
          req_one = HBC_LEG_LOW;
          req_two = HBC_LEG_LOW;
        end
        default:
        begin
          req_one = HBC_LEG_FLOAT;
          req_two = HBC_LEG_FLOAT;
        end
      endcase
    end
  end

  hbc_leg u_leg_one (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .leg_req (req_one),
    .gate    (bridge_output_one)
  );

  hbc_leg u_leg_two (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .leg_req (req_two),
    .gate    (bridge_output_two)
  );

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_active  <= 1'b1;
      fault_latched <= 1'b0;
    end
    else
    begin
      sleep_active  <= (state_r == HBC_ST_SLEEP) || (state_r == HBC_ST_WAKE);
      fault_latched <= (state_r == HBC_ST_FAULT);
    end
  end

endmodule : hbc_core

// >>> hbc_checker.sv
// assertion checker for the h-bridge control block
`timescale 1ns/100ps
module hbc_checker
  import hbc_pkg::*;
#(
  parameter int SLEEP_CNT = SLEEP_CYC,
  parameter int WAKE_CNT  = WAKE_CYC,
  parameter int OCP_CNT   = OCP_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bridge_input_a,
  input wire logic bridge_input_b,
  input wire logic chop_trip_current,
  input wire logic overcurrent_fault,
  input wire logic thermal_fault,
  input hbc_gate_t bridge_output_one,
  input hbc_gate_t bridge_output_two,
  input wire logic sleep_active,
  input wire logic fault_latched
);
  logic [31:0] quiet_r, busy_r, oc_r, hot_r, trip_r;
  logic        long_r;
  logic        off_w;
  logic        both_low_w;
  assign off_w = bridge_output_one == 2'h0 && bridge_output_two == 2'h0;
  assign both_low_w = bridge_output_one == 2'h1 && bridge_output_two == 2'h1;
  // raw pin run lengths; the design lags these by its sync stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {quiet_r, busy_r, oc_r, hot_r, trip_r} <= '0;
      long_r <= 1'b0;
    end
    else
    begin
      quiet_r <= (bridge_input_a || bridge_input_b) ? '0 : quiet_r + 1;
      busy_r <= (bridge_input_a || bridge_input_b) ? busy_r + 1 : '0;
      oc_r <= overcurrent_fault ? oc_r + 1 : '0;
      hot_r <= thermal_fault ? hot_r + 1 : '0;
      trip_r <= chop_trip_current ? trip_r + 1 : '0;
      long_r <= sleep_active ? 1'b0 : (long_r || oc_r >= OCP_CNT - 1);
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_chop_start;
    $rose(both_low_w) && bridge_input_a && !bridge_input_b;
  endsequence
  chk_leg_no_short: assert property (bridge_output_one != 2'h3 && bridge_output_two != 2'h3)
    else $error("leg with both switches on");
  chk_gap_before_low: assert property ($fell(bridge_output_one.high_on) |=> (!bridge_output_one.low_on) [*3])
    else $error("low switch on without gap");
  chk_sleep_entry: assert property (quiet_r == SLEEP_CNT + 20 |-> sleep_active && off_w)
    else $error("no sleep after quiet inputs");
  chk_wake_time: assert property ($fell(sleep_active) |-> busy_r >= WAKE_CNT)
    else $error("woke too early");
  chk_ocp_filter: assert property ($rose(fault_latched) |-> long_r)
    else $error("short overcurrent latched");
  chk_fault_off: assert property (fault_latched && $past(fault_latched, 3) |-> off_w)
    else $error("bridge driven in fault");
  chk_fault_clear: assert property ($fell(fault_latched) |-> quiet_r >= SLEEP_CNT)
    else $error("fault cleared without sleep");
  chk_thermal_off: assert property (hot_r >= 10 |-> off_w)
    else $error("bridge driven while hot");
  chk_chop_trip: assert property (trip_r == 35 |-> !bridge_output_one.high_on && !bridge_output_two.high_on)
    else $error("no chop after trip");
  chk_chop_resume: assert property (s_chop_start |-> ##[20:80] bridge_output_one.high_on)
    else $error("drive not resumed after off time");
endmodule : hbc_checker

bind hbc_core hbc_checker #(.SLEEP_CNT(SLEEP_CNT), .WAKE_CNT(WAKE_CNT), .OCP_CNT(OCP_CNT)) u_hbc_checker (
  .clk_sys           (clk_sys),
  .rst_n             (rst_n),
  .bridge_input_a    (bridge_input_a),
  .bridge_input_b    (bridge_input_b),
  .chop_trip_current (chop_trip_current),
  .overcurrent_fault (overcurrent_fault),
  .thermal_fault     (thermal_fault),
  .bridge_output_one (bridge_output_one),
  .bridge_output_two (bridge_output_two),
  .sleep_active      (sleep_active),
  .fault_latched     (fault_latched)
);

// >>> hbc_mcu_model.sv
// controller model driving the two bridge inputs
`timescale 1ns/100ps
module hbc_mcu_model
#(
  parameter int PWM_HALF = 300
)
(
  input  wire logic       clk_sys,
  input  wire logic [1:0] cmd,
  input  wire logic       pwm_en,
  output logic            bridge_input_a,
  output logic            bridge_input_b
);
  int unsigned cnt_r;
  initial
  begin
    cnt_r = 0;
    {bridge_input_a, bridge_input_b} = 2'h0;
  end
  // half period 3 us keeps below top modulation rate
  always @(posedge clk_sys)
  begin
    cnt_r <= (cnt_r + 1) % (2 * PWM_HALF);
    {bridge_input_a, bridge_input_b} <= #1 (pwm_en && cnt_r >= PWM_HALF) ? 2'h3 : cmd;
  end
endmodule : hbc_mcu_model

// >>> testbench.sv
// self-checking testbench for the h-bridge control block
`timescale 1ns/100ps
module testbench
  import hbc_pkg::*;
;
  logic       clk_sys = 0, rst_n = 0, pwm_en = 0;
  logic       trip = 0, oc = 0, hot = 0;
  logic [1:0] cmd = 2'h0;
  logic       in_a, in_b, sleep_active, fault_latched;
  hbc_gate_t  out_one, out_two;
  logic [3:0] outs;
  int         fail_count = 0;
  int         num_checks = 0;
  assign outs = {out_one, out_two};
  always #5 clk_sys = ~clk_sys;
  hbc_mcu_model u_hbc_mcu_model (.clk_sys(clk_sys), .cmd(cmd), .pwm_en(pwm_en),
    .bridge_input_a(in_a), .bridge_input_b(in_b));
  hbc_core #(.SLEEP_CNT(200), .WAKE_CNT(50), .OFF_CNT(40), .BLANK_CNT(5), .FILT_CNT(3)) u_hbc_core (
    .clk_sys(clk_sys), .rst_n(rst_n), .bridge_input_a(in_a), .bridge_input_b(in_b),
    .chop_trip_current(trip), .overcurrent_fault(oc), .thermal_fault(hot),
    .bridge_output_one(out_one), .bridge_output_two(out_two),
    .sleep_active(sleep_active), .fault_latched(fault_latched));
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic set_in(input logic [1:0] v);
    @(posedge clk_sys);
    #1 cmd = v;
  endtask : set_in
  task automatic t_decode;
    logic [1:0] in_tab [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    logic [3:0] g_tab [4] = '{4'h9, 4'h6, 4'h0, 4'h5};
    set_in(2'h2);
    cyc(20);
    check("asleep", {3'h0, sleep_active}, 4'h1);
    cyc(100);
    check("awake", {3'h0, sleep_active}, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      set_in(in_tab[i]);
      cyc(80);
      check("decode", outs, g_tab[i]);
    end
  endtask : t_decode
  task automatic t_glitch;
    // two-cycle dip on one input: passes the sync, must die in the filter
    set_in(2'h2);
    set_in(2'h2);
    set_in(2'h3);
    cyc(30);
    check("glitch", outs, 4'h5);
  endtask : t_glitch
  task automatic t_chop;
    set_in(2'h2);
    cyc(80);
    trip = 1;
    cyc(35);
    check("chop", outs, 4'h5);
    trip = 0;
    cyc(80);
    check("resume", outs, 4'h9);
  endtask : t_chop
  task automatic t_pwm;
    int nf = 0;
    int nb = 0;
    pwm_en = 1;
    repeat (1500)
    begin
      cyc(1);
      nf += (outs === 4'h9);
      nb += (outs === 4'h5);
    end
    pwm_en = 0;
    check("pwm", {2'h0, nf > 200, nb > 200}, 4'h3);
  endtask : t_pwm
  task automatic t_thermal;
    cyc(80);
    hot = 1;
    cyc(20);
    check("hot", outs, 4'h0);
    hot = 0;
    cyc(80);
    check("cool", outs, 4'h9);
  endtask : t_thermal
  task automatic t_fault;
    oc = 1;
    cyc(100);
    oc = 0;
    cyc(10);
    check("short oc", {fault_latched, outs}, 5'h09);
    oc = 1;
    cyc(200);
    oc = 0;
    check("fault", {fault_latched, outs}, 5'h10);
    set_in(2'h1);
    cyc(80);
    check("latched", {fault_latched, outs}, 5'h10);
    set_in(2'h0);
    cyc(260);
    check("cleared", {2'h0, sleep_active, fault_latched}, 4'h2);
  endtask : t_fault
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    #100us;
    fail_count++;
    final_report();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1;
    t_decode();
    t_glitch();
    t_chop();
    t_pwm();
    t_thermal();
    t_fault();
    final_report();
  end
endmodule : testbench
